// File: tw_pkg.sv
// Purpose: shared constants for the two-wire debug link register block
// Assumes: 8-bit link registers, link instructions sent lsb first
// Notes:   select, unlock and command codes for the block follow
package tw_pkg;
   // target select values
   localparam logic [7:0] TW_SEL_FAMILY  = 8'h00;
   localparam logic [7:0] TW_SEL_REV     = 8'h01;
   localparam logic [7:0] TW_SEL_UNLOCK  = 8'h02;
   localparam logic [7:0] TW_SEL_PORT    = 8'hb4;
   // unlock sequence codes
   localparam logic [7:0] TW_UNLOCK_1ST  = 8'h02;
   localparam logic [7:0] TW_UNLOCK_2ND  = 8'h01;
   // flash command codes
   localparam logic [7:0] TW_CMD_BLK_RD  = 8'h06;
   localparam logic [7:0] TW_CMD_BLK_WR  = 8'h07;
   localparam logic [7:0] TW_CMD_PG_ER   = 8'h08;
   localparam logic [7:0] TW_CMD_DEV_ER  = 8'h03;
   // reset value of the writable registers
   localparam logic [7:0] TW_RST_VAL     = 8'h00;
   // link instruction encoding: bit0 = write, bit1 = target select access
   localparam int         TW_INS_WR_BIT  = 0;
   localparam int         TW_INS_SEL_BIT = 1;
   localparam logic [2:0] TW_INS_LAST    = 3'h1;
   localparam logic [2:0] TW_BYTE_LAST   = 3'h7;
   // fifo word: flag marking a command byte above the byte
   localparam int         TW_FIFO_W      = 9;
   localparam int         TW_FIFO_D      = 16;
   localparam int         TW_CMD_FLAG    = 8;
endpackage : tw_pkg

// File: tw_fifo.sv
// Purpose: byte buffer between the programming port and the flash engine
// Assumes: single clock, read data shown while out_valid is high
// Notes:   full and empty come from an occupancy counter
`timescale 1ns/1ps
module tw_fifo #(
   parameter int W = 9,
   parameter int D = 16
) (
   input  wire logic         clk,       // core clock
   input  wire logic         rst,       // async reset, high
   input  wire logic [W-1:0] in_data,   // word to store
   input  wire logic         in_valid,  // store request
   output logic              in_ready,  // room left
   output logic [W-1:0]      out_data,  // oldest word
   output logic              out_valid, // not empty
   input  wire logic         out_ready  // drain request
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   // handshakes on both sides
   assign in_ready  = (cnt_r < (AW+1)'(D)); // full only at the depth itself
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage needs no reset
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(D-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(D-1)) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   // occupancy
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (push && !pop) begin
         cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule : tw_fifo

// File: tw_link.sv
// Purpose: bit-serial front end on the host-made link clock
// Assumes: host changes data after falling edge, device samples on rising edge
// Notes:   request/answer cross to core clock by toggle handshake
`timescale 1ns/1ps
module tw_link (
   input  wire logic       link_clk,  // link clock from host
   input  wire logic       rst,       // async reset, high
   input  wire logic       din,       // data pin level
   output logic            dout,      // data pin drive value
   output logic            doe,       // data pin drive enable
   output logic [1:0]      ins,       // instruction, held during request
   output logic [7:0]      wdata,     // write byte, held during request
   output logic            req_tgl,   // toggles per request
   input  wire logic       ack_tgl,   // core answer toggle
   input  wire logic [7:0] rdata      // core answer byte
);
   typedef enum logic [2:0] {
      L_IDLE, L_INS, L_WDATA, L_WAIT, L_READY, L_RDATA
   } tw_lst_t;
   tw_lst_t    st_r;
   logic [2:0] cnt_r;
   logic [1:0] ins_r;
   logic [7:0] sh_r;
   logic       req_r;
   logic       ack_s1_r;
   logic       ack_s2_r;
   logic       out_r;
   logic       oe_r;

   assign ins     = ins_r;
   assign wdata   = sh_r;
   assign req_tgl = req_r;
   assign dout    = out_r;
   assign doe     = oe_r;

   // answer toggle synchroniser
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         ack_s1_r <= ack_tgl;
         ack_s2_r <= ack_s1_r;
      end
   end

   // frame sequencer; host keeps clocking through the wait bits
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         st_r  <= L_IDLE;
         cnt_r <= 3'h0;
         ins_r <= 2'h0;
         sh_r  <= 8'h00;
         req_r <= 1'b0;
         out_r <= 1'b0;
         oe_r  <= 1'b0;
      end else begin
         case (st_r)
            L_IDLE: begin
               oe_r  <= 1'b0;
               cnt_r <= 3'h0;
               if (din) begin
                  st_r <= L_INS;
               end
            end
            L_INS: begin
               ins_r <= {din, ins_r[1]};
               cnt_r <= cnt_r + 3'h1;
               if (cnt_r == tw_pkg::TW_INS_LAST) begin
                  cnt_r <= 3'h0;
                  if (ins_r[1]) begin
                     st_r <= L_WDATA;
                  end else begin
                     req_r <= ~req_r;
                     st_r  <= L_WAIT;
                  end
               end
            end
            L_WDATA: begin
               sh_r  <= {din, sh_r[7:1]};
               cnt_r <= cnt_r + 3'h1;
               if (cnt_r == tw_pkg::TW_BYTE_LAST) begin
                  req_r <= ~req_r;
                  st_r  <= L_WAIT;
               end
            end
            L_WAIT: begin
               oe_r  <= 1'b1;
               out_r <= 1'b0;
               if (ack_s2_r == req_r) begin
                  out_r <= 1'b1;
                  sh_r  <= rdata;
                  st_r  <= L_READY;
               end
            end
            L_READY: begin
               cnt_r <= 3'h0;
               if (ins_r[tw_pkg::TW_INS_WR_BIT]) begin
                  oe_r <= 1'b0;
                  st_r <= L_IDLE;
               end else begin
                  out_r <= sh_r[0];
                  sh_r  <= {1'b0, sh_r[7:1]};
                  st_r  <= L_RDATA;
               end
            end
            L_RDATA: begin
               cnt_r <= cnt_r + 3'h1;
               out_r <= sh_r[0];
               sh_r  <= {1'b0, sh_r[7:1]};
               if (cnt_r == tw_pkg::TW_BYTE_LAST) begin
                  oe_r <= 1'b0;
                  st_r <= L_IDLE;
               end
            end
            default: begin
               st_r <= L_IDLE;
            end
         endcase
      end
   end
endmodule : tw_link

// File: tw_debug_regs.sv
// Purpose: two-wire debug link registers and flash programming front end
// Assumes: revision strap static; flash engine pulses op_done per operation
// Notes:   register file on core clock, serial logic on link clock
`timescale 1ns/1ps
module tw_debug_regs #(
   parameter logic [7:0] FAMILY_ID = 8'h5a  // arbitrary identifier value
) (
   input  wire logic       core_clk,             // core clock 125 MHz
   input  wire logic       rst,                  // async reset, high
   input  wire logic       debug_link_clock_pin, // link clock from host
   input  wire logic       debug_link_data_in,   // data pin level
   output logic            debug_link_data_out,  // data pin drive value
   output logic            debug_link_data_oe,   // data pin drive enable
   input  wire logic [7:0] silicon_rev_strap,    // die revision strap
   output logic [8:0]      flash_byte_data,      // {is_command, byte}
   output logic            flash_byte_valid,     // byte available
   input  wire logic       flash_byte_ready,     // engine takes byte
   input  wire logic [7:0] flash_rd_byte,        // byte read from flash
   input  wire logic       flash_rd_valid,       // load read byte into port
   input  wire logic       flash_op_done,        // engine finished operation
   output logic            prog_mode,            // programming unlocked
   output logic [7:0]      flash_cmd,            // active command code
   output logic            flash_busy            // operation in progress
);
   typedef enum logic [1:0] {U_LOCKED, U_FIRST, U_OPEN} tw_ust_t;

   logic [1:0] l_ins;
   logic [7:0] l_wdata;
   logic       l_req;
   logic       rq_s1_r;
   logic       rq_s2_r;
   logic       rq_s3_r;
   logic       pend_r;
   logic       ack_r;
   logic [7:0] rdata_r;
   logic [7:0] sel_r;
   logic [7:0] rev_r;
   logic       rev_done_r;
   logic [7:0] unlock_r;
   logic [7:0] port_r;
   tw_ust_t    ust_r;
   logic [7:0] cmd_r;
   logic       busy_r;
   logic       do_wr;
   logic       do_rd;
   logic       sel_acc;
   logic       port_wr;
   logic       push_v;
   logic [8:0] push_d;
   logic       push_rdy;
   logic       stall;
   logic       svc;
   logic       prog_r;
   logic [8:0] fifo_d;
   logic       fifo_v;
   logic       fifo_pop;
   logic [8:0] obuf_d_r;
   logic       obuf_v_r;

   // command codes the flash engine understands
   function automatic logic valid_cmd(input logic [7:0] c);
      valid_cmd = (c == tw_pkg::TW_CMD_BLK_RD) || (c == tw_pkg::TW_CMD_BLK_WR)
               || (c == tw_pkg::TW_CMD_PG_ER)  || (c == tw_pkg::TW_CMD_DEV_ER);
   endfunction : valid_cmd

   // serial side on its own clock
   tw_link u_link (
      .link_clk (debug_link_clock_pin),
      .rst      (rst),
      .din      (debug_link_data_in),
      .dout     (debug_link_data_out),
      .doe      (debug_link_data_oe),
      .ins      (l_ins),
      .wdata    (l_wdata),
      .req_tgl  (l_req),
      .ack_tgl  (ack_r),
      .rdata    (rdata_r)
   );

   // request toggle synchroniser; third stage only for edge detect
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rq_s1_r <= 1'b0;
         rq_s2_r <= 1'b0;
         rq_s3_r <= 1'b0;
      end else begin
         rq_s1_r <= l_req;
         rq_s2_r <= rq_s1_r;
         rq_s3_r <= rq_s2_r;
      end
   end

   // decode of the pending request; link holds ins/wdata until answered
   assign do_wr   = pend_r && l_ins[tw_pkg::TW_INS_WR_BIT];
   assign do_rd   = pend_r && !l_ins[tw_pkg::TW_INS_WR_BIT];
   assign sel_acc = l_ins[tw_pkg::TW_INS_SEL_BIT];
   assign port_wr = do_wr && !sel_acc && (sel_r == tw_pkg::TW_SEL_PORT);

   // bytes go to the engine only once unlocked, commands only if known
   always_comb begin
      push_v = 1'b0;
      push_d = {1'b0, l_wdata};
      if (port_wr && (ust_r == U_OPEN)) begin
         if (busy_r) begin
            push_v = 1'b1;
         end else if (valid_cmd(l_wdata)) begin
            push_v = 1'b1;
            push_d = {1'b1, l_wdata};
         end
      end
   end

   // a full buffer holds the answer back, so the host sees wait bits
   assign stall = push_v && !push_rdy;
   assign svc   = pend_r && !stall;

   // request pending flag and answer toggle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pend_r <= 1'b0;
         ack_r  <= 1'b0;
      end else begin
         if (rq_s2_r != rq_s3_r) begin
            pend_r <= 1'b1;
         end else if (svc) begin
            pend_r <= 1'b0;
         end
         if (svc) begin
            ack_r <= ~ack_r;
         end
      end
   end

   // read answer; unmapped selects read zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (do_rd && svc) begin
         if (sel_acc) begin
            rdata_r <= sel_r;
         end else if (sel_r == tw_pkg::TW_SEL_FAMILY) begin
            rdata_r <= FAMILY_ID;
         end else if (sel_r == tw_pkg::TW_SEL_REV) begin
            rdata_r <= rev_r;
         end else if (sel_r == tw_pkg::TW_SEL_UNLOCK) begin
            rdata_r <= unlock_r;
         end else if (sel_r == tw_pkg::TW_SEL_PORT) begin
            rdata_r <= port_r;
         end else begin
            rdata_r <= 8'h00;
         end
      end
   end

   // target select register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sel_r <= tw_pkg::TW_RST_VAL;
      end else if (do_wr && svc && sel_acc) begin
         sel_r <= l_wdata;
      end
   end

   // revision strap caught once after reset release, then frozen
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rev_r      <= 8'h00;
         rev_done_r <= 1'b0;
      end else if (!rev_done_r) begin
         rev_r      <= silicon_rev_strap;
         rev_done_r <= 1'b1;
      end
   end

   // unlock register and its two-code sequence; open is sticky
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         unlock_r <= tw_pkg::TW_RST_VAL;
         ust_r    <= U_LOCKED;
         prog_r   <= 1'b0;
      end else if (do_wr && svc && !sel_acc && (sel_r == tw_pkg::TW_SEL_UNLOCK)) begin
         unlock_r <= l_wdata;
         case (ust_r)
            U_LOCKED: begin
               if (l_wdata == tw_pkg::TW_UNLOCK_1ST) begin
                  ust_r <= U_FIRST;
               end
            end
            U_FIRST: begin
               if (l_wdata == tw_pkg::TW_UNLOCK_2ND) begin
                  ust_r  <= U_OPEN;
                  prog_r <= 1'b1;
               end else if (l_wdata != tw_pkg::TW_UNLOCK_1ST) begin
                  ust_r <= U_LOCKED;
               end
            end
            default: begin
               ust_r <= U_OPEN;
            end
         endcase
      end
   end

   // programming data port; a host write beats a flash read load
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         port_r <= tw_pkg::TW_RST_VAL;
      end else if (port_wr && svc) begin
         port_r <= l_wdata;
      end else if (flash_rd_valid && (ust_r == U_OPEN)) begin
         port_r <= flash_rd_byte;
      end
   end

   // active command; a new command wins over a same-cycle done
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd_r  <= 8'h00;
         busy_r <= 1'b0;
      end else if (push_v && svc && push_d[tw_pkg::TW_CMD_FLAG]) begin
         cmd_r  <= l_wdata;
         busy_r <= 1'b1;
      end else if (flash_op_done) begin
         busy_r <= 1'b0;
      end
   end

   // outputs from registers
   assign prog_mode        = prog_r;
   assign flash_cmd        = cmd_r;
   assign flash_busy       = busy_r;
   assign flash_byte_data  = obuf_d_r;
   assign flash_byte_valid = obuf_v_r;

   // registered head byte; the engine sees flops, at the cost of one extra slot
   assign fifo_pop = fifo_v && (!obuf_v_r || flash_byte_ready);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         obuf_v_r <= 1'b0;
         obuf_d_r <= 9'h000;
      end else if (fifo_pop) begin
         obuf_v_r <= 1'b1;
         obuf_d_r <= fifo_d;
      end else if (flash_byte_ready) begin
         obuf_v_r <= 1'b0;
      end
   end

   // byte buffer toward the flash engine
   tw_fifo #(
      .W (tw_pkg::TW_FIFO_W),
      .D (tw_pkg::TW_FIFO_D)
   ) u_fifo (
      .clk       (core_clk),
      .rst       (rst),
      .in_data   (push_d),
      .in_valid  (push_v && svc),
      .in_ready  (push_rdy),
      .out_data  (fifo_d),
      .out_valid (fifo_v),
      .out_ready (fifo_pop)
   );
endmodule : tw_debug_regs

// File: tw_host.sv
// Purpose: host adapter model on the two-wire debug link
// Assumes: pull-up on the data pin; clock idles low between frames
// Notes:   xfer runs one whole frame, waits a bounded time for ready
`timescale 1ns/1ps
module tw_host (
   output logic      lk,   // link clock
   output logic      din,  // resolved pin level
   input  wire logic dout, // device drive value
   input  wire logic doe   // device drive enable
);
   logic h_d;  // host drive value
   logic h_oe; // host drive enable
   // device drive wins; a released pin floats up
   assign din = doe ? dout : (h_oe ? h_d : 1'b1);
   initial begin
      lk   = 1'b0;
      h_d  = 1'b0;
      h_oe = 1'b0;
   end
   // one link cycle; clock runs only inside frames, data moves after fall
   task automatic tick();
      #40 lk = 1'b1;
      #40 lk = 1'b0;
   endtask : tick
   // start, instruction, write byte, then the answer
   task automatic xfer(input logic [1:0] ins, input logic [7:0] wd,
                       output logic [7:0] rd, output logic ok);
      int n;
      #3;
      rd   = 8'h00;
      h_oe = 1'b1;
      h_d  = 1'b1;
      tick();
      for (int i = 0; i < 2; i++) begin
         h_d = ins[i];
         tick();
      end
      for (int i = 0; i < 8 && ins[0]; i++) begin
         h_d = wd[i];
         tick();
      end
      // let go before the device turns the pin round
      h_oe = 1'b0;
      n    = 0;
      do begin
         tick();
         n++;
      end while (!(doe && dout) && n < 400);
      ok = (n < 400);
      for (int i = 0; i < 8 && !ins[0]; i++) begin
         tick();
         rd[i] = dout;
      end
      tick();
   endtask : xfer
endmodule : tw_host

// File: tw_debug_regs_chk.sv
// Purpose: port assertions for the debug link register block
// Assumes: both domains cleared by rst
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module tw_chk (
   input wire logic       core_clk,             // core clock
   input wire logic       rst,                  // async reset
   input wire logic       debug_link_clock_pin, // link clock
   input wire logic       debug_link_data_out,  // pin value
   input wire logic       debug_link_data_oe,   // pin enable
   input wire logic [8:0] flash_byte_data,      // buffer head
   input wire logic       flash_byte_valid,     // not empty
   input wire logic       flash_byte_ready,     // engine pop
   input wire logic       prog_mode,            // unlocked
   input wire logic [7:0] flash_cmd,            // command
   input wire logic       flash_busy            // op running
);
   // only the four listed codes may ever start an operation
   function automatic logic is_code(input logic [7:0] c);
      return c inside {tw_pkg::TW_CMD_BLK_RD, tw_pkg::TW_CMD_BLK_WR,
                       tw_pkg::TW_CMD_PG_ER, tw_pkg::TW_CMD_DEV_ER};
   endfunction : is_code
   sequence s_release;
      $fell(rst);
   endsequence
   sequence s_quiet4;
      (!prog_mode && !flash_byte_valid && !flash_busy)[*4];
   endsequence
   sequence s_turn;
      $rose(debug_link_data_oe);
   endsequence
   property p_rst_quiet;
      @(posedge core_clk) disable iff (rst) s_release |-> s_quiet4;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
   property p_sticky;
      @(posedge core_clk) disable iff (rst) prog_mode |=> prog_mode;
   endproperty
   a_sticky: assert property (p_sticky) else $error("programming mode lost");
   property p_locked_buf;
      @(posedge core_clk) disable iff (rst) !prog_mode |-> !flash_byte_valid;
   endproperty
   a_locked_buf: assert property (p_locked_buf) else $error("byte sent while locked");
   property p_locked_cmd;
      @(posedge core_clk) disable iff (rst)
         !prog_mode |-> (flash_cmd == 8'h00 && !flash_busy);
   endproperty
   a_locked_cmd: assert property (p_locked_cmd) else $error("op while locked");
   property p_hold;
      @(posedge core_clk) disable iff (rst) flash_byte_valid && !flash_byte_ready
         |=> flash_byte_valid && $stable(flash_byte_data);
   endproperty
   a_hold: assert property (p_hold) else $error("head byte changed unread");
   property p_cmd_code;
      @(posedge core_clk) disable iff (rst)
         flash_byte_valid && flash_byte_data[8] |-> is_code(flash_byte_data[7:0]);
   endproperty
   a_cmd_code: assert property (p_cmd_code) else $error("bad command forwarded");
   property p_busy_code;
      @(posedge core_clk) disable iff (rst) flash_busy |-> is_code(flash_cmd);
   endproperty
   a_busy_code: assert property (p_busy_code) else $error("busy on bad code");
   property p_turn;
      @(posedge debug_link_clock_pin) disable iff (rst) s_turn |-> !debug_link_data_out;
   endproperty
   a_turn: assert property (p_turn) else $error("answer not opened by wait");
endmodule : tw_chk
bind tw_debug_regs tw_chk i_chk (.core_clk, .rst, .debug_link_clock_pin,
   .debug_link_data_out, .debug_link_data_oe, .flash_byte_data, .flash_byte_valid,
   .flash_byte_ready, .prog_mode, .flash_cmd, .flash_busy);

// File: two_wire_debug_flash_regs_tb.sv
// Purpose: self-checking bench for the debug link register block
// Assumes: host model drives the link; bench plays the flash engine
// Notes:   random strap and bytes from a fixed seed
`timescale 1ns/1ps
module two_wire_debug_flash_regs_tb;
   localparam logic [7:0] FAM = 8'h3c; // arbitrary identifier value
   logic       core_clk, rst, lk, din, dout, doe, ok;
   logic       fbv, fbr, frv, fod, pm, busy;
   logic [7:0] strap, frb, fcmd, rd, b;
   logic [8:0] fbd;
   logic [7:0] cmd_codes [4];
   int         err_total, n_compared;
   tw_debug_regs #(.FAMILY_ID(FAM)) i_dut (.core_clk, .rst,
      .debug_link_clock_pin(lk), .debug_link_data_in(din), .debug_link_data_out(dout),
      .debug_link_data_oe(doe), .silicon_rev_strap(strap), .flash_byte_data(fbd),
      .flash_byte_valid(fbv), .flash_byte_ready(fbr), .flash_rd_byte(frb),
      .flash_rd_valid(frv), .flash_op_done(fod), .prog_mode(pm), .flash_cmd(fcmd),
      .flash_busy(busy));
   tw_host i_host (.lk, .din, .dout, .doe);
   always #4 core_clk = ~core_clk;
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // expected read-back of the fixed and unmapped selects
   function automatic logic [7:0] exp_id(input logic [7:0] a);
      if (a == tw_pkg::TW_SEL_FAMILY) begin
         return FAM;
      end else if (a == tw_pkg::TW_SEL_REV) begin
         return strap;
      end
      return 8'h00;
   endfunction : exp_id
   task automatic tally_and_finish();
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   // link write, sel picks the target select register
   task automatic wr(input logic sel, input logic [7:0] v);
      i_host.xfer({sel, 1'b1}, v, rd, ok);
      chk({8'h00, ok}, 9'h001);
   endtask : wr
   task automatic rd_chk(input logic sel, input logic [7:0] exp);
      i_host.xfer({sel, 1'b0}, 8'h00, rd, ok);
      chk({ok, rd}, {1'b1, exp});
   endtask : rd_chk
   task automatic rd_at(input logic [7:0] a, input logic [7:0] exp);
      wr(1'b1, a);
      rd_chk(1'b0, exp);
   endtask : rd_at
   // engine side: wait for a byte, compare, pop it
   task automatic pop(input logic [8:0] exp);
      int n;
      n = 0;
      @(negedge core_clk);
      while (fbv !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      chk({8'h00, fbv}, 9'h001);
      chk(fbd, exp);
      fbr = 1'b1;
      @(negedge core_clk);
      fbr = 1'b0;
   endtask : pop
   task automatic done_pulse();
      @(negedge core_clk);
      fod = 1'b1;
      @(negedge core_clk);
      fod = 1'b0;
      @(negedge core_clk);
   endtask : done_pulse
   // watchdog well past the expected run length
   initial begin
      #400000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      core_clk   = 1'b0;
      rst        = 1'b1;
      {fbr, frv, fod, frb, strap} = '0;
      err_total  = 0;
      n_compared = 0;
      cmd_codes  = '{tw_pkg::TW_CMD_BLK_RD, tw_pkg::TW_CMD_BLK_WR,
                     tw_pkg::TW_CMD_PG_ER, tw_pkg::TW_CMD_DEV_ER};
      void'($urandom(69));
      strap = 8'($urandom);
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      rd_chk(1'b1, 8'h00);
      rd_at(tw_pkg::TW_SEL_UNLOCK, 8'h00);
      rd_at(tw_pkg::TW_SEL_PORT, 8'h00);
      rd_at(8'h77, exp_id(8'h77));
      rd_at(tw_pkg::TW_SEL_REV, exp_id(tw_pkg::TW_SEL_REV));
      wr(1'b0, ~strap);
      rd_chk(1'b0, strap);
      rd_at(tw_pkg::TW_SEL_FAMILY, exp_id(tw_pkg::TW_SEL_FAMILY));
      wr(1'b0, ~FAM);
      rd_chk(1'b0, FAM);
      // locked: the port keeps the byte, the engine sees nothing
      wr(1'b1, tw_pkg::TW_SEL_PORT);
      wr(1'b0, tw_pkg::TW_CMD_BLK_RD);
      rd_chk(1'b0, tw_pkg::TW_CMD_BLK_RD);
      chk({7'h00, pm, fbv}, 9'h000);
      // wrong order first, then the proper pair
      wr(1'b1, tw_pkg::TW_SEL_UNLOCK);
      wr(1'b0, tw_pkg::TW_UNLOCK_2ND);
      wr(1'b0, tw_pkg::TW_UNLOCK_1ST);
      chk({8'h00, pm}, 9'h000);
      wr(1'b0, tw_pkg::TW_UNLOCK_2ND);
      chk({8'h00, pm}, 9'h001);
      wr(1'b0, 8'h00);
      chk({8'h00, pm}, 9'h001);
      // every command with one random byte behind it
      wr(1'b1, tw_pkg::TW_SEL_PORT);
      foreach (cmd_codes[k]) begin
         b = 8'($urandom);
         wr(1'b0, cmd_codes[k]);
         wr(1'b0, b);
         pop({1'b1, cmd_codes[k]});
         pop({1'b0, b});
         chk({1'b0, fcmd}, {1'b0, cmd_codes[k]});
         chk({8'h00, busy}, 9'h001);
         done_pulse();
         chk({8'h00, busy}, 9'h000);
      end
      wr(1'b0, 8'h05);
      repeat (8) @(negedge core_clk);
      chk({8'h00, fbv}, 9'h000);
      b   = 8'($urandom);
      frb = b;
      frv = 1'b1;
      @(negedge core_clk);
      frv = 1'b0;
      rd_chk(1'b0, b);
      // fill buffer and head stage; the eighteenth byte stalls until drained
      wr(1'b0, tw_pkg::TW_CMD_BLK_WR);
      for (int i = 0; i < 16; i++) wr(1'b0, 8'h40 + 8'(i));
      fork
         wr(1'b0, 8'h50);
         begin
            repeat (400) @(negedge core_clk);
            pop({1'b1, tw_pkg::TW_CMD_BLK_WR});
            for (int i = 0; i < 17; i++) pop({1'b0, 8'h40 + 8'(i)});
         end
      join
      @(negedge core_clk);
      chk({8'h00, fbv}, 9'h000);
      done_pulse();
      // reset in mid-run is the only way out of programming
      rst = 1'b1;
      i_host.tick();
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      chk({8'h00, pm}, 9'h000);
      rd_chk(1'b1, 8'h00);
      rd_at(tw_pkg::TW_SEL_UNLOCK, 8'h00);
      tally_and_finish();
   end
endmodule : two_wire_debug_flash_regs_tb
